//--- src/stms_mode_switch.sv
// Speed/torque control mode arbitration with delayed switching and analog routing
`timescale 1ns/1ps
module stms_mode_switch
  import stms_pkg::*;
#(
  parameter int unsigned MS_CYCLES = CYCLES_PER_MS
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [NUM_DI-1:0] di_level_i,
  input wire logic [NUM_DI-1:0][7:0] digital_input_function_select_i,
  input wire logic [2:0] control_method_select_i,
  input wire logic torque_control_select_i,
  input wire logic [DELAY_W-1:0] mode_switch_delay_i,
  input wire logic [1:0] frequency_ref_source_select_i,
  input wire logic [1:0] speed_limit_source_select_i,
  input wire logic [4:0] multi_analog_function_select_i,
  input wire logic [NUM_AI-1:0][AI_RAW_W-1:0] ai_raw_i,
  input wire stms_ai_cal_t [NUM_AI-1:0] ai_cal_i,
  input wire stms_tlim_set_t constant_torque_limits_i,
  output logic torque_mode_o,
  output logic switch_delay_o,
  output logic decel_stop_o,
  output logic signed [VAL_W-1:0] speed_ref_o,
  output logic signed [VAL_W-1:0] torque_ref_o,
  output stms_tlim_t torque_limit_o
);

  // Gain and bias applied to one raw sample
  function automatic logic signed [VAL_W-1:0] scale_ai(input logic [AI_RAW_W-1:0] raw, input stms_ai_cal_t cal);
    logic [AI_RAW_W+GAIN_W-1:0] prod;
    prod = raw * cal.gain;
    scale_ai = $signed({2'b00, prod[AI_FS_SHIFT +: VAL_W-2]}) + VAL_W'(cal.bias);
  endfunction

  // Smaller of analog magnitude and constant limit
  function automatic logic [VAL_W-1:0] lim_min(input logic [VAL_W-1:0] mag, input logic [TLIM_W-1:0] cst);
    logic [VAL_W-1:0] cst_s;
    // Widen before the multiply: 300 % times ten does not fit in the setting's width
    cst_s = VAL_W'(cst) * VAL_W'(TLIM_SCALE);
    lim_min = (mag < cst_s) ? mag : cst_s;
  endfunction

  stms_mode_t mode_reg, mode_next;
  logic delay_reg, delay_next;
  logic sw_prev_reg, sw_prev_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [DELAY_W-1:0] ms_reg, ms_next;
  logic [NUM_AI-1:0][AI_RAW_W-1:0] frz_reg, frz_next;
  logic sw_assigned, sw_level, sw_enabled, sw_edge;
  logic [NUM_AI-1:0][AI_RAW_W-1:0] ai_used;
  logic signed [VAL_W-1:0] ai_val [NUM_AI];

  // Any input carrying function 71 assigns the switch; active inputs OR together
  always_comb
  begin
    sw_assigned = 1'b0;
    sw_level = 1'b0;
    for (int i = 0; i < NUM_DI; i++)
    begin
      if (digital_input_function_select_i[i] == DI_FUNC_MODE_SWITCH)
      begin
        sw_assigned = 1'b1;
        sw_level = sw_level | di_level_i[i];
      end
    end
  end

  assign sw_enabled = sw_assigned && (control_method_select_i == CTRL_METHOD_FLUX_VECTOR);
  assign sw_edge = sw_enabled && (sw_level != sw_prev_reg);

  // Mode, delay timer and freeze capture
  always_comb
  begin
    mode_next = mode_reg;
    delay_next = delay_reg;
    sw_prev_next = sw_level;
    pre_next = pre_reg;
    ms_next = ms_reg;
    frz_next = frz_reg;
    if (!run_i)
    begin
      // Stopping always runs in speed control; mode drops to speed on the same edge the stop flag sets
      mode_next = STMS_SPEED;
      delay_next = 1'b0;
    end
    else if (!sw_enabled)
    begin
      mode_next = torque_control_select_i ? STMS_TORQUE : STMS_SPEED;
      delay_next = 1'b0;
    end
    else if (sw_edge && (mode_switch_delay_i != DELAY_DEFAULT))
    begin
      // Each edge restarts the wait and resamples the analog inputs
      delay_next = 1'b1;
      pre_next = '0;
      ms_next = '0;
      frz_next = ai_raw_i;
    end
    else if (delay_reg)
    begin
      if (pre_reg == PRE_W'(MS_CYCLES - 1))
      begin
        pre_next = '0;
        ms_next = ms_reg + 1'b1;
        if ((ms_reg + 1'b1) >= mode_switch_delay_i)
        begin
          delay_next = 1'b0;
          mode_next = sw_level ? STMS_TORQUE : STMS_SPEED;
        end
      end
      else
      begin
        pre_next = pre_reg + 1'b1;
      end
    end
    else
    begin
      // No delay pending: mode tracks the switch input directly
      mode_next = sw_level ? STMS_TORQUE : STMS_SPEED;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg <= STMS_SPEED;
      delay_reg <= 1'b0;
      sw_prev_reg <= 1'b0;
      pre_reg <= '0;
      ms_reg <= '0;
      frz_reg <= '0;
    end
    else
    begin
      mode_reg <= mode_next;
      delay_reg <= delay_next;
      sw_prev_reg <= sw_prev_next;
      pre_reg <= pre_next;
      ms_reg <= ms_next;
      frz_reg <= frz_next;
    end
  end

  // Frozen samples replace live ones while the delay runs
  assign ai_used = delay_reg ? frz_reg : ai_raw_i;
  for (genvar g = 0; g < NUM_AI; g++)
  begin : g_scale
    assign ai_val[g] = scale_ai(ai_used[g], ai_cal_i[g]);
  end

  logic torque_mode_next, decel_next;
  logic signed [VAL_W-1:0] speed_ref_next, torque_ref_next;
  stms_tlim_t tlim_next;
  logic tref_assigned;
  logic [VAL_W-1:0] tmag;

  // Output routing; source codes past the last channel fall back to channel 0
  always_comb
  begin
    tref_assigned = (multi_analog_function_select_i == AI_FUNC_TORQUE_REF);
    tmag = ai_val[AI_MULTI][VAL_W-1] ? VAL_W'(-ai_val[AI_MULTI]) : VAL_W'(ai_val[AI_MULTI]);
    torque_mode_next = (mode_reg == STMS_TORQUE);
    decel_next = !run_i;
    if (mode_reg == STMS_SPEED)
    begin
      speed_ref_next = (frequency_ref_source_select_i < NUM_AI) ? ai_val[frequency_ref_source_select_i] :
        ai_val[AI_VOLT];
      torque_ref_next = '0;
    end
    else
    begin
      speed_ref_next = (speed_limit_source_select_i < NUM_AI) ? ai_val[speed_limit_source_select_i] :
        ai_val[AI_VOLT];
      torque_ref_next = tref_assigned ? ai_val[AI_MULTI] : '0;
    end
    // In speed control the torque reference channel limits both directions
    if (tref_assigned && (mode_reg == STMS_SPEED))
    begin
      tlim_next.fwd_mot = lim_min(tmag, constant_torque_limits_i.fwd_mot);
      tlim_next.rev_mot = lim_min(tmag, constant_torque_limits_i.rev_mot);
      tlim_next.fwd_regen = lim_min(tmag, constant_torque_limits_i.fwd_regen);
      tlim_next.rev_regen = lim_min(tmag, constant_torque_limits_i.rev_regen);
    end
    else
    begin
      tlim_next.fwd_mot = VAL_W'(constant_torque_limits_i.fwd_mot) * VAL_W'(TLIM_SCALE);
      tlim_next.rev_mot = VAL_W'(constant_torque_limits_i.rev_mot) * VAL_W'(TLIM_SCALE);
      tlim_next.fwd_regen = VAL_W'(constant_torque_limits_i.fwd_regen) * VAL_W'(TLIM_SCALE);
      tlim_next.rev_regen = VAL_W'(constant_torque_limits_i.rev_regen) * VAL_W'(TLIM_SCALE);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      torque_mode_o <= 1'b0;
      decel_stop_o <= 1'b0;
      speed_ref_o <= '0;
      torque_ref_o <= '0;
      torque_limit_o <= '0;
    end
    else
    begin
      torque_mode_o <= torque_mode_next;
      decel_stop_o <= decel_next;
      speed_ref_o <= speed_ref_next;
      torque_ref_o <= torque_ref_next;
      torque_limit_o <= tlim_next;
    end
  end

  assign switch_delay_o = delay_reg;

  // Checks on mode and routing behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  full_scale_gain_a: assert property (!delay_reg && ai_raw_i[AI_VOLT] == AI_RAW_FULL
    && ai_cal_i[AI_VOLT].gain == GAIN_DEFAULT && ai_cal_i[AI_VOLT].bias == BIAS_DEFAULT
    |-> ai_val[AI_VOLT] == VAL_FULL)
    else $error("full scale input not at 100 percent");
  zero_input_bias_a: assert property (!delay_reg && mode_reg == STMS_SPEED
    && frequency_ref_source_select_i == AI_VOLT && ai_raw_i[0] == '0
    |=> speed_ref_o == VAL_W'($past(ai_cal_i[0].bias)))
    else $error("zero input does not give bias");
  switch_follow_a: assert property (run_i && sw_enabled && mode_switch_delay_i == '0 && !delay_reg
    && $stable(sw_level) |=> ##1 torque_mode_o == $past(sw_level, 2))
    else $error("mode does not follow switch input");
  base_select_a: assert property (run_i && !sw_assigned ##1 run_i && !sw_assigned
    |=> torque_mode_o == $past(torque_control_select_i, 2))
    else $error("base mode not from select");
  delay_start_a: assert property (run_i && sw_edge && mode_switch_delay_i != '0
    |=> switch_delay_o && $stable(mode_reg))
    else $error("delay not started on edge");
  no_assign_delay_a: assert property (!sw_assigned |=> !switch_delay_o)
    else $error("delay active without switch input");
  freeze_hold_a: assert property (delay_reg && !sw_edge && run_i |=> $stable(frz_reg))
    else $error("frozen analog values changed");
  torque_lim_min_a: assert property (1'b1 |=> torque_limit_o.fwd_mot <=
    VAL_W'($past(constant_torque_limits_i.fwd_mot)) * VAL_W'(TLIM_SCALE))
    else $error("torque limit above constant");
  // Stop flag one edge after run drops, speed mode visible one edge later
  stop_speed_a: assert property (!run_i |=> decel_stop_o ##1 !torque_mode_o)
    else $error("run removed without speed stop");
  tref_zero_a: assert property (mode_reg == STMS_TORQUE && !tref_assigned |=> torque_ref_o == '0)
    else $error("torque reference without assignment");

  torque_entry_c: cover property ($rose(torque_mode_o));
  delay_run_c: cover property ($fell(switch_delay_o) && run_i);
  restart_c: cover property (delay_reg && sw_edge);
  torque_stop_c: cover property (torque_mode_o && !run_i);
endmodule

//--- src/stms_pkg.sv
// Package for the speed/torque mode switch: constants, field types and modes
// Summary of operation
// - Analog gain 0.0..1000.0 %, default 100.0 %; full scale gives 100 %.
// - Analog bias -100.0..+100.0 %, default 0; bias is value at minimum input.
// - Input with function 71: inactive means speed control, active means torque control.
// - Torque control select: 0 speed, 1 torque; default 0.
// - Mode change waits 0..1000 ms after each switch input edge, default 0.
// - Switching delay only applies when some input has function 71.
// - During switching delay all three analog values stay frozen.
// - Speed control uses frequency reference source; torque control uses speed-limit source.
// - Torque reference channel is torque limit in speed, reference in torque.
// - Torque limit is smaller of analog magnitude and constant limit.
// - Run removed in speed control: decelerate to stop.
// - Run removed in torque control: change to speed control, then decelerate; here the stop flag sets one edge before torque mode clears.
// - Input-driven switching works only with control method 3.
// - Four constant torque limits, 0..300 %, default 200 %.
// - Analog function 13 marks torque reference; limits both directions in speed.
package stms_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned PRE_W = 18;
  localparam int unsigned NUM_DI = 6;
  localparam int unsigned NUM_AI = 3;
  // Channel order: voltage reference, multi-function, current reference
  localparam logic [1:0] AI_VOLT = 2'h0;
  localparam logic [1:0] AI_MULTI = 2'h1;
  localparam logic [1:0] AI_CURR = 2'h2;
  localparam logic [7:0] DI_FUNC_MODE_SWITCH = 8'h47;
  localparam logic [4:0] AI_FUNC_TORQUE_REF = 5'h0d;
  localparam logic [2:0] CTRL_METHOD_FLUX_VECTOR = 3'h3;
  // Raw converter code, full scale (10 V / 20 mA) is 1 << AI_FS_SHIFT
  localparam int unsigned AI_RAW_W = 13;
  localparam int unsigned AI_FS_SHIFT = 12;
  localparam logic [AI_RAW_W-1:0] AI_RAW_FULL = 13'h1000;
  localparam int unsigned GAIN_W = 14;
  localparam logic [GAIN_W-1:0] GAIN_DEFAULT = 14'h03e8;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 14'h2710;
  localparam int unsigned BIAS_W = 11;
  localparam logic signed [BIAS_W-1:0] BIAS_DEFAULT = 11'sh000;
  localparam int unsigned DELAY_W = 10;
  localparam logic [DELAY_W-1:0] DELAY_DEFAULT = 10'h000;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 10'h3e8;
  localparam int unsigned TLIM_W = 9;
  localparam logic [TLIM_W-1:0] TLIM_DEFAULT = 9'h0c8;
  localparam logic [TLIM_W-1:0] TLIM_MAX = 9'h12c;
  localparam logic [3:0] TLIM_SCALE = 4'ha;
  localparam logic TORQUE_SEL_DEFAULT = 1'b0;
  // Scaled values in 0.1 % steps, signed
  localparam int unsigned VAL_W = 17;
  localparam logic signed [VAL_W-1:0] VAL_FULL = 17'sh003e8;

  typedef enum logic {STMS_SPEED, STMS_TORQUE} stms_mode_t;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic signed [BIAS_W-1:0] bias;
  } stms_ai_cal_t;

  typedef struct packed {
    logic [TLIM_W-1:0] fwd_mot;
    logic [TLIM_W-1:0] rev_mot;
    logic [TLIM_W-1:0] fwd_regen;
    logic [TLIM_W-1:0] rev_regen;
  } stms_tlim_set_t;

  typedef struct packed {
    logic [VAL_W-1:0] fwd_mot;
    logic [VAL_W-1:0] rev_mot;
    logic [VAL_W-1:0] fwd_regen;
    logic [VAL_W-1:0] rev_regen;
  } stms_tlim_t;
endpackage

//--- test/stms_host_model.sv
// Host controller model: run command, mode-switch terminal, base mode select and analog levels
`timescale 1ns/1ps
module stms_host_model
  import stms_pkg::*;
(
  input wire logic mclk_i,
  output logic run_o,
  output logic sw_o,
  output logic torque_sel_o,
  output logic [NUM_AI-1:0][AI_RAW_W-1:0] ai_raw_o
);
  // Idle host: stopped, switch off, speed as base mode
  initial
  begin
    run_o = 1'b0;
    sw_o = 1'b0;
    torque_sel_o = TORQUE_SEL_DEFAULT;
    ai_raw_o = '0;
  end

  // Every change lands just after a rising edge, so the block sees it one edge later
  task automatic set_run(input logic v);
    @(posedge mclk_i);
    run_o <= v;
  endtask

  task automatic set_sw(input logic v);
    @(posedge mclk_i);
    sw_o <= v;
  endtask

  // Only used where input switching is disabled; otherwise left at speed
  task automatic set_tsel(input logic v);
    @(posedge mclk_i);
    torque_sel_o <= v;
  endtask

  task automatic set_ai(input int ch, input logic [AI_RAW_W-1:0] v);
    @(posedge mclk_i);
    ai_raw_o[ch] <= v;
  endtask
endmodule

//--- test/speed_torque_mode_switch_test.sv
// Self-checking bench for the speed/torque mode switch
`timescale 1ns/1ps
module speed_torque_mode_switch_test;
  import stms_pkg::*;
  logic mclk_i;
  logic rst_n_i;
  logic run, sw, tsel;
  logic [NUM_AI-1:0][AI_RAW_W-1:0] ai_raw;
  logic [NUM_DI-1:0][7:0] fsel;
  logic [4:0] di_lo;
  logic [2:0] method;
  logic [DELAY_W-1:0] dly;
  logic [1:0] fsrc, slsrc;
  logic [4:0] mfunc;
  stms_ai_cal_t [NUM_AI-1:0] cal;
  stms_tlim_set_t tlim;
  logic tmode, sdel, decel;
  logic signed [VAL_W-1:0] sref, tref;
  stms_tlim_t tl;
  int n_errors = 0;
  int n_tests = 0;

  stms_host_model i_host (.mclk_i(mclk_i), .run_o(run), .sw_o(sw), .torque_sel_o(tsel), .ai_raw_o(ai_raw));

  // Short millisecond so a 2 ms delay is 8 cycles
  stms_mode_switch #(.MS_CYCLES(4)) i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(run), .di_level_i({sw, di_lo}),
    .digital_input_function_select_i(fsel), .control_method_select_i(method),
    .torque_control_select_i(tsel), .mode_switch_delay_i(dly),
    .frequency_ref_source_select_i(fsrc), .speed_limit_source_select_i(slsrc),
    .multi_analog_function_select_i(mfunc), .ai_raw_i(ai_raw), .ai_cal_i(cal),
    .constant_torque_limits_i(tlim), .torque_mode_o(tmode), .switch_delay_o(sdel),
    .decel_stop_o(decel), .speed_ref_o(sref), .torque_ref_o(tref), .torque_limit_o(tl));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [VAL_W-1:0] got, input logic [VAL_W-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sample 1 ns after the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run is little more than a hundred cycles; this only catches a hang
  initial
  begin
    #20000;
    n_errors++;
    end_sim;
  end

  initial
  begin
    rst_n_i = 1'b0;
    fsel = '0;
    fsel[5] = DI_FUNC_MODE_SWITCH;
    di_lo = '0;
    method = CTRL_METHOD_FLUX_VECTOR;
    dly = DELAY_DEFAULT;
    fsrc = AI_VOLT;
    slsrc = AI_CURR;
    mfunc = AI_FUNC_TORQUE_REF;
    for (int i = 0; i < NUM_AI; i++) cal[i] = '{gain: GAIN_DEFAULT, bias: BIAS_DEFAULT};
    tlim = '{TLIM_DEFAULT, TLIM_DEFAULT, TLIM_DEFAULT, TLIM_DEFAULT};
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    i_host.set_run(1'b1);
    i_host.set_ai(0, 13'h0800);
    i_host.set_ai(1, 13'h1000);
    i_host.set_ai(2, 13'h0400);
    cyc(4);
    // Half scale at unity gain, full scale channel 1 limits below 200 %
    chk(sref, 17'h001f4);
    chk(tmode, 1'b0);
    chk(tref, 17'h00000);
    chk(tl.fwd_mot, 17'h003e8);
    chk(tl.rev_regen, 17'h003e8);
    @(posedge mclk_i);
    cal[0].bias <= 11'h79c;
    cal[1].gain <= GAIN_MAX;
    tlim.rev_mot <= 9'h032;
    cyc(3);
    chk(sref, 17'h00190);
    chk(tl.fwd_mot, 17'h007d0);
    chk(tl.rev_mot, 17'h001f4);
    $display("Test scaling done");
    // Immediate switch to torque control
    i_host.set_sw(1'b1);
    cyc(3);
    chk(tmode, 1'b1);
    chk(tref, 17'h02710);
    chk(sref, 17'h000fa);
    chk(tl.fwd_mot, 17'h007d0);
    // Run removed in torque control falls back to speed
    i_host.set_run(1'b0);
    cyc(3);
    chk(decel, 1'b1);
    chk(tmode, 1'b0);
    i_host.set_sw(1'b0);
    i_host.set_run(1'b1);
    cyc(3);
    chk(decel, 1'b0);
    i_host.set_run(1'b0);
    cyc(3);
    chk(decel, 1'b1);
    chk(tmode, 1'b0);
    i_host.set_run(1'b1);
    $display("Test stopping done");
    // 2 ms delay with frozen analog values
    @(posedge mclk_i);
    dly <= 10'h002;
    cyc(2);
    i_host.set_sw(1'b1);
    cyc(2);
    chk(sdel, 1'b1);
    i_host.set_ai(0, 13'h0000);
    i_host.set_ai(1, 13'h0800);
    cyc(1);
    chk(sref, 17'h00190);
    chk(tmode, 1'b0);
    cyc(7);
    chk(sdel, 1'b0);
    chk(tmode, 1'b1);
    chk(tref, 17'h01388);
    // Edge inside the delay restarts it and refreezes
    i_host.set_sw(1'b0);
    i_host.set_ai(1, 13'h0400);
    cyc(4);
    chk(tref, 17'h01388);
    i_host.set_sw(1'b1);
    cyc(5);
    chk(sdel, 1'b1);
    chk(tmode, 1'b1);
    chk(tref, 17'h009c4);
    cyc(8);
    chk(sdel, 1'b0);
    $display("Test delay done");
    // Switch input ignored outside the encoder vector method
    @(posedge mclk_i);
    method <= 3'h2;
    cyc(3);
    chk(tmode, 1'b0);
    i_host.set_sw(1'b0);
    cyc(2);
    chk(sdel, 1'b0);
    i_host.set_tsel(1'b1);
    cyc(3);
    chk(tmode, 1'b1);
    i_host.set_tsel(1'b0);
    @(posedge mclk_i);
    method <= CTRL_METHOD_FLUX_VECTOR;
    fsel[5] <= 8'h00;
    i_host.set_sw(1'b1);
    cyc(3);
    chk(tmode, 1'b0);
    chk(sdel, 1'b0);
    $display("Test gating done");
    // Routing: ch0 full scale at unity, ch2 at 200 % gain and +10.0 % bias, new constant limits
    @(posedge mclk_i);
    cal[0].bias <= BIAS_DEFAULT;
    cal[2] <= '{gain: 14'h07d0, bias: 11'h064};
    fsrc <= AI_CURR;
    tlim.fwd_mot <= 9'h12c;
    tlim.fwd_regen <= 9'h000;
    tlim.rev_regen <= 9'h064;
    i_host.set_ai(0, AI_RAW_FULL);
    cyc(3);
    chk(sref, 17'h00258);
    chk(tl.fwd_mot, 17'h009c4);
    chk(tl.fwd_regen, 17'h00000);
    chk(tl.rev_regen, 17'h003e8);
    // Unused source code falls back to ch0; ch1 no longer a torque reference
    @(posedge mclk_i);
    fsrc <= 2'h3;
    mfunc <= 5'h0e;
    cyc(3);
    chk(sref, 17'h003e8);
    chk(tl.fwd_mot, 17'h00bb8);
    chk(tl.rev_mot, 17'h001f4);
    // Switch on another input with no delay; speed limit from ch0, no torque reference
    @(posedge mclk_i);
    dly <= DELAY_DEFAULT;
    slsrc <= AI_VOLT;
    fsel[0] <= DI_FUNC_MODE_SWITCH;
    di_lo <= 5'h01;
    cyc(3);
    chk(tmode, 1'b1);
    chk(sref, 17'h003e8);
    chk(tref, 17'h00000);
    chk(tl.fwd_regen, 17'h00000);
    $display("Test routing done");
    end_sim;
  end
endmodule
